// ===== test/testbench.sv
// Self-checking bench of the watchdog countdown block
`timescale 1ns/100ps
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module testbench;
    import wdcd_pkg::*;
    logic clk = 1'h0, nrst = 1'h0, hsel = 1'h0, hwrite = 1'h0, ao = 1'h0, rs = 1'h1, stop_req = 1'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, e_rd;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hrdata;
    logic hready, hresp, osc, stop_mode, srst, srec, irq, rd_ph = 1'h0;
    logic [31:0] q[$];
    int n_mismatch = 0, samples_checked = 0, ticks = 0, n, i;

    wdcd_watchdog_unit #(.RELOAD_DEFAULT(RELOAD_RESET)) wdcd_watchdog_unit_inst (.core_clk_i(clk),
        .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .rc_osc_i(osc), .always_on_option_i(ao), .reset_response_option_i(rs),
        .stop_mode_i(stop_mode), .sys_reset_req_o(srst), .stop_recovery_o(srec), .irq_o(irq));
    wdcd_core_model wdcd_core_model_inst (.core_clk_i(clk), .stop_req_i(stop_req), .recovery_i(srec),
        .rc_osc_o(osc), .stop_mode_o(stop_mode));

    always #10 clk = ~clk;
    always @(posedge osc) ticks++;

    // Read results are compared in the order the reads were issued
    always @(posedge clk)
    begin
        if (rd_ph && hready === 1'h1)
        begin
            e_rd = q.pop_front();
            `CHK("read data", e_rd, hrdata)
            `CHK("read response", 1'h0, hresp)
        end
        if (hready === 1'h1)
            rd_ph <= hsel && htrans[1] && !hwrite;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'h1 && ++k < 20);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'h1 && ++k < 20);
        if (k >= 20)
        begin
            n_mismatch++;
            stop_test();
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        xfer(1'h0, a, 32'h0000_0000);
    endtask : rd

    // Waits a bounded time for a reset request or a recovery pulse
    task automatic wt(input logic rec, input int lim);
        int k;
        for (k = 0; k < lim; k++)
        begin
            @(posedge clk);
            if ((rec ? srec : srst) === 1'h1)
                break;
        end
        `CHK("time-out pulse", 1, int'(k < lim))
        if (k >= lim)
            stop_test();
    endtask : wt

    task automatic do_rst(input logic a, input logic r);
        nrst <= 1'h0;
        ao <= a;
        rs <= r;
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
    endtask : do_rst

    initial
    begin
        void'($urandom(55));
        do_rst(1'h0, 1'h1);
        rd(ADDR_RELOAD_HIGH, 32'h0000_0004);
        rd(ADDR_CTRL, 32'h0000_0004);
        rd(8'h20, 32'h0000_0000);
        repeat (60) @(posedge clk);
        rd(ADDR_COUNT, 32'h0000_0400);
        $display("test reset values done");

        n = $urandom_range(12, 6);
        wr(ADDR_RELOAD_HIGH, 32'h0000_0000);
        // reload kept at four or more
        wr(ADDR_RELOAD_LOW, n);
        rd(ADDR_RELOAD_LOW, n);
        @(posedge osc);
        repeat (5) @(posedge clk);
        wr(ADDR_CTRL, 32'h0000_0001);
        ticks = 0;
        wt(1'h0, 20 * n);
        `CHK("ticks to time-out", n, ticks)
        rd(ADDR_CTRL, 32'h0000_0005);
        rd(ADDR_RESET_CAUSE, 32'h0000_0001);
        wr(ADDR_RESET_CAUSE, 32'h0000_0001);
        $display("test reset response done");

        repeat (n - 2) @(posedge osc);
        @(posedge clk);
        wr(ADDR_IRQ_MASK, 32'h0000_0002);
        wr(ADDR_CTRL, 32'h0000_0001);
        wt(1'h0, 50);
        `CHK("irq refused", 1'h1, irq)
        rd(ADDR_IRQ_STATUS, 32'h0000_0002);
        rd(ADDR_RESET_CAUSE, 32'h0000_0001);
        wr(ADDR_IRQ_MASK, 32'h0000_0000);
        @(posedge clk);
        `CHK("irq masked", 1'h0, irq)
        wr(ADDR_IRQ_STATUS, 32'h0000_0002);
        rd(ADDR_IRQ_STATUS, 32'h0000_0000);
        $display("test late refresh done");

        do_rst(1'h1, 1'h0);
        rd(ADDR_CTRL, 32'h0000_0003);
        wr(ADDR_RELOAD_HIGH, 32'h0000_0000);
        wr(ADDR_RELOAD_LOW, n);
        wr(ADDR_IRQ_MASK, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0001);
        stop_req <= 1'h1;
        @(posedge clk);
        stop_req <= 1'h0;
        wt(1'h1, 20 * n);
        for (i = 0; i < 10 && irq !== 1'h1; i++)
            @(posedge clk);
        `CHK("irq after recovery", 1'h1, irq)
        if (irq !== 1'h1)
            stop_test();
        `CHK("stop mode left", 1'h0, stop_mode)
        rd(ADDR_RESET_CAUSE, 32'h0000_0003);
        rd(ADDR_IRQ_STATUS, 32'h0000_0001);
        $display("test stop recovery done");
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule : testbench

// ===== test/wdcd_core_model.sv
// Model of the oscillator and the core beside the watchdog
`timescale 1ns/100ps
module wdcd_core_model (
    input wire logic core_clk_i,
    input wire logic stop_req_i,
    input wire logic recovery_i,
    output logic rc_osc_o,
    output logic stop_mode_o
);
    initial rc_osc_o = 1'h0;
    initial stop_mode_o = 1'h0;
    // free oscillator
    // Period of 10.4 clocks drifts against the core clock but never lands on a rising edge
    always #104 rc_osc_o = ~rc_osc_o;
    always @(posedge core_clk_i)
    begin
        if (recovery_i)
            stop_mode_o <= 1'h0;
        else if (stop_req_i)
            stop_mode_o <= 1'h1;
    end
endmodule : wdcd_core_model

// ===== test/wdcd_properties.sv
// Port checker for the watchdog countdown block
`timescale 1ns/100ps
module wdcd_properties (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic rc_osc_i,
    input wire logic stop_mode_i,
    input wire logic sys_reset_req_o,
    input wire logic stop_recovery_o,
    input wire logic irq_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    property p_okay;
        hresp_o == 1'h0;
    endproperty
    a_okay: assert property (p_okay) else $error("error response seen");

    property p_rd_wait;
        hsel_i && htrans_i[1] && !hwrite_i && hready_i |=> !hreadyout_o ##1 hreadyout_o;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

    property p_wr_fast;
        hsel_i && htrans_i[1] && hwrite_i && hready_i |=> hreadyout_o;
    endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write was stalled");

    property p_rst_once;
        sys_reset_req_o |=> !sys_reset_req_o;
    endproperty
    a_rst_once: assert property (p_rst_once) else $error("reset request too long");

    property p_rst_run;
        sys_reset_req_o |-> !$past(stop_mode_i) && !stop_recovery_o;
    endproperty
    a_rst_run: assert property (p_rst_run) else $error("reset request in stop");

    property p_recov;
        stop_recovery_o |-> $past(stop_mode_i) ##1 !stop_recovery_o;
    endproperty
    a_recov: assert property (p_recov) else $error("recovery pulse wrong");

    property p_irq_late;
        $rose(irq_o) |-> !stop_recovery_o && !$past(stop_recovery_o);
    endproperty
    a_irq_late: assert property (p_irq_late) else $error("irq before recovery over");

    // A time-out shows five clocks after the oscillator rise that brought it, never without one
    property p_quiet;
        sys_reset_req_o || stop_recovery_o |-> $past(rc_osc_i, 5) && !$past(rc_osc_i, 6);
    endproperty
    a_quiet: assert property (p_quiet) else $error("time-out without oscillator edge");
endmodule : wdcd_properties

bind wdcd_watchdog_unit wdcd_properties wdcd_properties_inst (.core_clk_i, .nrst_i, .hsel_i, .htrans_i,
    .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .rc_osc_i, .stop_mode_i, .sys_reset_req_o,
    .stop_recovery_o, .irq_o);

// ===== verilog/wdcd_osc_sync.sv
// Synchroniser and rising-edge tick for the watchdog RC oscillator input
`timescale 1ns/100ps
module wdcd_osc_sync #(
    parameter int unsigned STAGES = wdcd_pkg::SYNC_STAGES
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic osc_i,
    output logic tick_o
);
    import wdcd_pkg::*;

    typedef struct packed {
        logic [STAGES-1:0] sync;
        logic level;
        logic tick;
    } wdcd_osc_state_s;

    wdcd_osc_state_s cur;
    wdcd_osc_state_s next_cur;
    logic stable;

    generate
        if (STAGES < 3)
        begin : g_bad_stages
            $error("wdcd_osc_sync needs at least three stages");
        end
    endgenerate

    always_comb
    begin
        next_cur = cur;
        next_cur.sync = {cur.sync[STAGES-2:0], osc_i};
        // Only the last two stages are compared; the first one may be metastable
        stable = (cur.sync[STAGES-1] == cur.sync[STAGES-2]);
        next_cur.level = stable ? cur.sync[STAGES-1] : cur.level;
        next_cur.tick = stable && cur.sync[STAGES-1] && !cur.level;
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign tick_o = cur.tick;

endmodule : wdcd_osc_sync

// ===== verilog/wdcd_pkg.sv
// Shared constants, register map and types of the watchdog countdown block
package wdcd_pkg;

    localparam int unsigned BYTE_W = 8;
    localparam int unsigned COUNT_W = 24;
    localparam int unsigned CAUSE_W = 2;
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned SYNC_STAGES = 3;

    // Register byte addresses
    localparam logic [7:0] ADDR_RELOAD_UPPER = 8'h00;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h04;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_COUNT = 8'h10;
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

    // Control register fields
    localparam int unsigned CTRL_REFRESH_BIT = 0;
    localparam int unsigned CTRL_ON_BIT = 0;
    localparam int unsigned CTRL_ALWAYS_ON_BIT = 1;
    localparam int unsigned CTRL_RESET_RESP_BIT = 2;

    // Reset cause status fields
    localparam int unsigned CAUSE_WATCHDOG_BIT = 0;
    localparam int unsigned CAUSE_STOP_BIT = 1;

    // Interrupt status and mask fields
    localparam int unsigned IRQ_TIMEOUT_BIT = 0;
    localparam int unsigned IRQ_REFUSED_BIT = 1;

    // Count thresholds
    localparam logic [COUNT_W-1:0] TERMINAL_COUNT = 24'h00_0001;
    localparam logic [COUNT_W-1:0] REFRESH_LOCK = 24'h00_0002;
    localparam logic [COUNT_W-1:0] RELOAD_MIN = 24'h00_0004;
    localparam logic [COUNT_W-1:0] RELOAD_RESET = 24'h00_0400;

    // Reset values
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_STATUS_RESET = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // Clock rates; the oscillator must be sampled at least four times per period
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned OSC_TYP_HZ = 10_000;
    localparam int unsigned OSC_MIN_SAMPLES = 4;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ_WAIT,
        BUS_READ_DONE
    } wdcd_phase_e;

endpackage : wdcd_pkg

// ===== verilog/wdcd_watchdog_unit.sv
// Watchdog countdown timer with AHB-Lite register slave
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
// How it works
// RULE1: A time-out while in stop mode starts stop-mode recovery and sets both the watchdog and stop cause flags.
// RULE2: With interrupt response, a time-out in stop mode raises its interrupt only after recovery has finished.
// RULE3: The timer is one-shot: at terminal count it resets or interrupts the device. Here the count reloads from the bytes and the timer stays on.
// RULE4: The count is driven by a separate RC oscillator of about 10 kHz, not by the system clock.
// RULE5: The timer is only on or off; once on it counts without pause and must be refreshed in time.
// RULE6: It turns on by a refresh command or by the always-on option, which starts counting right after reset.
// RULE7: The counter is a 24-bit down-counter reloaded from upper, high and low 8-bit reload bytes.
// RULE8: Once the count is at 2 or below a refresh is ignored and the time-out goes ahead.
// RULE9: Software must not program a reload value below 4.
// RULE10: One count per oscillator period, so the time-out in ms is the reload value over 10.
// RULE11: The time-out response is selectable between system reset and interrupt.
// RULE12: In normal or halt mode the reset response option at 1 gives a reset and at 0 an interrupt.
// RULE13: A watchdog-initiated reset sets the watchdog cause flag.
// RULE14: A valid refresh reloads the counter from the three reload bytes.
// RULE15: While off the counter holds and gives neither reset nor interrupt.
module wdcd_watchdog_unit #(
    parameter logic [wdcd_pkg::COUNT_W-1:0] RELOAD_DEFAULT = wdcd_pkg::RELOAD_RESET
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic rc_osc_i,
    input wire logic always_on_option_i,
    input wire logic reset_response_option_i,
    input wire logic stop_mode_i,
    output logic sys_reset_req_o,
    output logic stop_recovery_o,
    output logic irq_o
);
    import wdcd_pkg::*;

    typedef struct packed {
        wdcd_phase_e phase;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic opt_done;
        logic always_on;
        logic reset_resp;
        logic on;
        logic [COUNT_W-1:0] count;
        logic [BYTE_W-1:0] reload_upper_byte;
        logic [BYTE_W-1:0] reload_high_byte;
        logic [BYTE_W-1:0] reload_low_byte;
        logic [CAUSE_W-1:0] reset_cause_status;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic irq_pending;
        logic sys_reset;
        logic recovery;
    } wdcd_state_s;

    wdcd_state_s cur;
    wdcd_state_s next_cur;
    logic tick;
    logic accept;
    logic refresh_cmd;
    logic refresh_ok;
    logic timeout;
    logic [COUNT_W-1:0] reload;
    logic [31:0] rd_data;
    logic [CAUSE_W-1:0] set_cause;
    logic [CAUSE_W-1:0] clr_cause;
    logic [IRQ_W-1:0] set_irq;
    logic [IRQ_W-1:0] clr_irq;

    generate
        if (RELOAD_DEFAULT < RELOAD_MIN)
        begin : g_bad_reload
            $error("wdcd_watchdog_unit reload default below the minimum");
        end
        if (CLK_HZ < OSC_MIN_SAMPLES * OSC_TYP_HZ)
        begin : g_bad_clock
            $error("wdcd_watchdog_unit core clock too slow to sample the oscillator");
        end
    endgenerate

    // RULE4: independent oscillator
    wdcd_osc_sync #(
        .STAGES(SYNC_STAGES)
    ) u_osc_sync (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .osc_i(rc_osc_i),
        .tick_o(tick)
    );

    // RULE7: upper, high, low byte order
    assign reload = {cur.reload_upper_byte, cur.reload_high_byte, cur.reload_low_byte};

    // Single transfers only; sequential beats are taken like non-sequential ones
    assign accept = hsel_i && hready_i && htrans_i[1];

    always_comb
    begin
        next_cur = cur;
        refresh_cmd = 1'b0;
        refresh_ok = 1'b0;
        timeout = 1'b0;
        rd_data = RDATA_RESET;
        set_cause = '0;
        clr_cause = '0;
        set_irq = '0;
        clr_irq = '0;
        next_cur.sys_reset = 1'b0;
        next_cur.recovery = 1'b0;

        // Straps are caught in the first clock after reset release
        if (!cur.opt_done)
        begin
            next_cur.opt_done = 1'b1;
            next_cur.always_on = always_on_option_i;
            next_cur.reset_resp = reset_response_option_i;
            // RULE6: always-on start
            if (always_on_option_i)
            begin
                next_cur.on = 1'b1;
                next_cur.count = reload;
            end
        end

        // Write data phase
        if (cur.phase == BUS_WRITE)
        begin
            case (cur.addr)
                ADDR_RELOAD_UPPER:
                begin
                    next_cur.reload_upper_byte = hwdata_i[BYTE_W-1:0];
                end
                ADDR_RELOAD_HIGH:
                begin
                    next_cur.reload_high_byte = hwdata_i[BYTE_W-1:0];
                end
                ADDR_RELOAD_LOW:
                begin
                    next_cur.reload_low_byte = hwdata_i[BYTE_W-1:0];
                end
                ADDR_CTRL:
                begin
                    refresh_cmd = hwdata_i[CTRL_REFRESH_BIT];
                end
                ADDR_RESET_CAUSE:
                begin
                    clr_cause = hwdata_i[CAUSE_W-1:0];
                end
                ADDR_IRQ_STATUS:
                begin
                    clr_irq = hwdata_i[IRQ_W-1:0];
                end
                ADDR_IRQ_MASK:
                begin
                    next_cur.irq_mask = hwdata_i[IRQ_W-1:0];
                end
                default:
                begin
                    refresh_cmd = 1'b0;
                end
            endcase
        end

        // Read data is taken one cycle late so a write just before is seen
        case (cur.addr)
            ADDR_RELOAD_UPPER:
            begin
                rd_data[BYTE_W-1:0] = cur.reload_upper_byte;
            end
            ADDR_RELOAD_HIGH:
            begin
                rd_data[BYTE_W-1:0] = cur.reload_high_byte;
            end
            ADDR_RELOAD_LOW:
            begin
                rd_data[BYTE_W-1:0] = cur.reload_low_byte;
            end
            ADDR_CTRL:
            begin
                rd_data[CTRL_ON_BIT] = cur.on;
                rd_data[CTRL_ALWAYS_ON_BIT] = cur.always_on;
                rd_data[CTRL_RESET_RESP_BIT] = cur.reset_resp;
            end
            ADDR_COUNT:
            begin
                rd_data[COUNT_W-1:0] = cur.count;
            end
            ADDR_RESET_CAUSE:
            begin
                rd_data[CAUSE_W-1:0] = cur.reset_cause_status;
            end
            ADDR_IRQ_STATUS:
            begin
                rd_data[IRQ_W-1:0] = cur.irq_status;
            end
            ADDR_IRQ_MASK:
            begin
                rd_data[IRQ_W-1:0] = cur.irq_mask;
            end
            default:
            begin
                rd_data = RDATA_RESET;
            end
        endcase

        // Bus phase sequencing
        if (cur.phase == BUS_READ_WAIT)
        begin
            next_cur.phase = BUS_READ_DONE;
            next_cur.rdata = rd_data;
        end
        else if (accept)
        begin
            next_cur.phase = hwrite_i ? BUS_WRITE : BUS_READ_WAIT;
            next_cur.addr = {haddr_i[7:2], 2'h0};
        end
        else
        begin
            next_cur.phase = BUS_IDLE;
        end

        // RULE2: deferred interrupt after recovery
        if (cur.irq_pending && !stop_mode_i && !cur.recovery)
        begin
            next_cur.irq_pending = 1'b0;
            set_irq[IRQ_TIMEOUT_BIT] = 1'b1;
        end

        // RULE8: refresh locked near terminal count
        refresh_ok = refresh_cmd && (!cur.on || (cur.count > REFRESH_LOCK));
        if (refresh_cmd && !refresh_ok)
        begin
            set_irq[IRQ_REFUSED_BIT] = 1'b1;
        end

        // RULE5: on until reset, counts every tick
        if (refresh_ok)
        begin
            // RULE14: reload from bytes
            next_cur.on = 1'b1;
            next_cur.count = reload;
        end
        // RULE15: hold while off
        else if (cur.on && tick)
        begin
            // RULE10: one count per tick
            if (cur.count <= TERMINAL_COUNT)
            begin
                // RULE3: terminal count, reload and keep counting
                timeout = 1'b1;
                next_cur.count = reload;
            end
            else
            begin
                next_cur.count = cur.count - TERMINAL_COUNT;
            end
        end

        if (timeout)
        begin
            if (stop_mode_i)
            begin
                // RULE1: stop-mode recovery and both flags
                next_cur.recovery = 1'b1;
                set_cause[CAUSE_WATCHDOG_BIT] = 1'b1;
                set_cause[CAUSE_STOP_BIT] = 1'b1;
                if (!cur.reset_resp)
                begin
                    next_cur.irq_pending = 1'b1;
                end
            end
            // RULE11: reset or interrupt
            else if (cur.reset_resp)
            begin
                // RULE12: option at one resets
                next_cur.sys_reset = 1'b1;
                // RULE13: watchdog cause flag
                set_cause[CAUSE_WATCHDOG_BIT] = 1'b1;
            end
            else
            begin
                // RULE12: option at zero interrupts
                set_irq[IRQ_TIMEOUT_BIT] = 1'b1;
            end
        end

        // Hardware set wins over a software clear in the same cycle
        next_cur.reset_cause_status = (cur.reset_cause_status & ~clr_cause) | set_cause;
        next_cur.irq_status = (cur.irq_status & ~clr_irq) | set_irq;
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cur <= '0;
            cur.phase <= BUS_IDLE;
            cur.rdata <= RDATA_RESET;
            cur.count <= RELOAD_DEFAULT;
            cur.reload_upper_byte <= RELOAD_DEFAULT[23:16];
            cur.reload_high_byte <= RELOAD_DEFAULT[15:8];
            cur.reload_low_byte <= RELOAD_DEFAULT[7:0];
            cur.reset_cause_status <= CAUSE_RESET;
            cur.irq_status <= IRQ_STATUS_RESET;
            cur.irq_mask <= IRQ_MASK_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign hrdata_o = cur.rdata;
    assign hreadyout_o = (cur.phase != BUS_READ_WAIT);
    assign hresp_o = 1'b0;
    assign sys_reset_req_o = cur.sys_reset;
    assign stop_recovery_o = cur.recovery;
    assign irq_o = |(cur.irq_status & cur.irq_mask);

endmodule : wdcd_watchdog_unit
